// ===== src/esr_pkg.sv
// Purpose: Shared constants and types of the engine speed setpoint regulator.
// Assumes: 100 MHz system clock, one periodic control tick.
// Notes:   Percentages are held in 0.01 % units, speeds in rpm.
package esr_pkg;
   // Data width of speeds, currents and measured quantities.
   localparam int W = 16;
   // Fraction bits of the ramp accumulator.
   localparam int FRAC = 8;
   localparam int RW = W + FRAC;
   // Control tick timing.
   localparam int CLK_HZ = 100_000_000;
   localparam int TICK_PERIOD_MS = 10;
   localparam int MS_PER_S = 1000;
   localparam int TICK_CYCLES = CLK_HZ / MS_PER_S * TICK_PERIOD_MS;
   localparam int TICK_HZ = MS_PER_S / TICK_PERIOD_MS;
   // Regulation source selector codes.
   localparam logic [3:0] SRC_VOLTAGE = 4'h0;
   localparam logic [3:0] SRC_CURRENT = 4'h1;
   localparam logic [3:0] SRC_BUMP = 4'h2;
   localparam logic [3:0] SRC_DIRECT = 4'h3;
   localparam logic [3:0] SRC_ANALOG_MIN = 4'h4;
   // Full scale of the internal command, 100.00 %.
   localparam logic [13:0] PCT_FULL = 14'h2710;
   localparam logic [13:0] CMD_RESET = 14'h0000;
   // Ramp rates that switch the ramp off, in %/s.
   localparam logic [7:0] RAMP_OFF_LO = 8'h00;
   localparam logic [7:0] RAMP_OFF_HI = 8'h64;
   // Percent scale times tick rate, divisor of the ramp step.
   localparam logic [31:0] RAMP_DEN = 32'h0000_2710;
   // Loop option bits.
   localparam int OPT_INVERT = 0;
   localparam int OPT_CLUTCH = 1;
   localparam int OPT_BREAKER = 2;
   // Synchronised pin positions.
   localparam int IN_INC = 0;
   localparam int IN_DEC = 1;
   localparam int IN_RST = 2;
   localparam int IN_GCB = 3;
   localparam int IN_CLUTCH = 4;
   localparam int N_IN = 5;
   // Right shift applied to the loop gain product.
   localparam int GAIN_SHIFT = 8;
   localparam logic [W-1:0] ZERO_W = 16'h0000;
   typedef enum logic [1:0] {ST_STOPPED, ST_DELAY, ST_RUN} esr_state_t;
endpackage

// ===== src/esr_tick.sv
// Purpose: Divides the system clock into a one-cycle control tick.
// Assumes: DIV of two or more.
// Notes:   The tick is registered, so it has no glitch.
`timescale 1ns/1ps
module esr_tick #(
   parameter int DIV = 1000
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Tick pulse.
   output logic tick
);
   if (DIV < 2) begin : g_bad_div
      $error("esr_tick: DIV must be at least 2");
   end

   logic [31:0] count;

   // Count up one tick period and pulse at the end.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= 32'h0000_0000;
         tick <= 1'b0;
      end else if (count == 32'(DIV - 1)) begin
         count <= 32'h0000_0000;
         tick <= 1'b1;
      end else begin
         count <= count + 32'h0000_0001;
         tick <= 1'b0;
      end
   end
endmodule

// ===== src/esr_sync.sv
// Purpose: Two-stage synchroniser with rising-edge pulse per pin.
// Assumes: Pins are asynchronous to clk.
// Notes:   Edge detection looks only at the second stage.
`timescale 1ns/1ps
module esr_sync #(
   parameter int WIDTH = 5
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Raw pins.
   input wire logic [WIDTH-1:0] pin,
   // Synchronised level and rising-edge pulse.
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise
);
   if (WIDTH < 1) begin : g_bad_width
      $error("esr_sync: WIDTH must be at least 1");
   end

   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic meta;
      logic level_d;
      // First stage is read by the second stage only; the edge costs two more flops.
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            meta <= 1'b0;
            level[i] <= 1'b0;
            level_d <= 1'b0;
            rise[i] <= 1'b0;
         end else begin
            meta <= pin[i];
            level[i] <= meta;
            level_d <= level[i];
            rise[i] <= level[i] & ~level_d;
         end
      end
   end
endmodule

// ===== src/esr_regulator.sv
// Purpose: Engine speed setpoint regulator: source select, loop, bump, ramp.
// Assumes: Configuration inputs are quasi-static; min_speed <= max_speed.
// Notes:   Summary of operation follows.
// Summary of operation
// - Current source regulates measured generator current.
// - Current below desired raises speed command.
// - Zero nominal uses generator current rating.
// - No analogue setpoint: use setpoint setting.
// - Zero setpoint in current mode uses rating.
// - Bump source steps speed reference.
// - Bump needs increase and decrease inputs.
// - Reset loads rated speed into setpoint.
// - Increase adds step, saturates at maximum.
// - Decrease subtracts step, saturates at minimum.
// - Zero nominal uses engine speed rating.
// - Setpoint changes pass through the ramp.
// - After start ramp from idle speed.
// - Commands ignored until activation delay elapses.
// - Optional: commands only with breaker closed.
// - Port commands act like digital inputs.
// - Direct source requests setpoint, no loop.
// - Ramp rate is percent per second.
// - Analogue source regulates that input quantity.
// - Errors are percent of nominal value.
// - Option: loop active only with clutch.
// - Inactive loop outputs fixed offset command.
// - Option bit inverts error polarity.
// - Command 0..100 % maps min..max speed.
// - Ramp rate 0 or 100 disables ramp.
// - Hold command inside the dead band.
`timescale 1ns/1ps
module esr_regulator
   import esr_pkg::*;
#(
   parameter int TICK_DIV = esr_pkg::TICK_CYCLES
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Configuration.
   input wire logic [3:0] source_select,
   input wire logic [esr_pkg::W-1:0] nominal_value,
   input wire logic [esr_pkg::W-1:0] setpoint_value,
   input wire logic [esr_pkg::W-1:0] current_rating,
   input wire logic [esr_pkg::W-1:0] speed_rating,
   input wire logic [esr_pkg::W-1:0] min_speed,
   input wire logic [esr_pkg::W-1:0] max_speed,
   input wire logic [esr_pkg::W-1:0] idle_speed,
   input wire logic [esr_pkg::W-1:0] speed_step,
   input wire logic [7:0] ramp_rate,
   input wire logic [13:0] dead_band,
   input wire logic [13:0] offset_command,
   input wire logic [esr_pkg::W-1:0] loop_gain,
   input wire logic [esr_pkg::W-1:0] activation_delay,
   input wire logic [2:0] loop_options,
   input wire logic increase_assigned,
   input wire logic decrease_assigned,
   // Measurements.
   input wire logic [esr_pkg::W-1:0] gen_current,
   input wire logic [esr_pkg::W-1:0] analog_measure,
   input wire logic [esr_pkg::W-1:0] analog_setpoint,
   input wire logic analog_setpoint_assigned,
   input wire logic engine_running,
   // Pins.
   input wire logic speed_increase_input,
   input wire logic speed_decrease_input,
   input wire logic speed_reset_input,
   input wire logic generator_breaker,
   input wire logic clutch_engaged,
   // Communication port commands, one-cycle pulses.
   input wire logic comm_increase,
   input wire logic comm_decrease,
   input wire logic comm_reset,
   // Results.
   output logic [esr_pkg::W-1:0] speed_request,
   output logic [esr_pkg::W-1:0] speed_setpoint,
   output logic [13:0] speed_command,
   output logic loop_active
);
   import esr_pkg::*;

   if (TICK_DIV < 2) begin : g_bad_div
      $error("esr_regulator: TICK_DIV must be at least 2");
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////
   // Tick and pin synchronisers.

   logic tick;
   logic [N_IN-1:0] pin_level;
   logic [N_IN-1:0] pin_rise;

   esr_tick #(.DIV(TICK_DIV)) u_tick (
      .clk(clk),
      .rst(rst),
      .tick(tick)
   );

   esr_sync #(.WIDTH(N_IN)) u_sync (
      .clk(clk),
      .rst(rst),
      .pin({clutch_engaged, generator_breaker, speed_reset_input,
            speed_decrease_input, speed_increase_input}),
      .level(pin_level),
      .rise(pin_rise)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Source selection and reference values.

   logic speed_mode;
   logic loop_mode;
   logic [W-1:0] rated_speed;
   logic [W-1:0] nom_eff;
   logic [W-1:0] actual;
   logic [W-1:0] desired;
   logic [W-1:0] target;

   // Rated and nominal references per source; all combinational.
   always_comb begin
      speed_mode = (source_select == SRC_BUMP) || (source_select == SRC_DIRECT);
      loop_mode = (source_select == SRC_CURRENT) || (source_select >= SRC_ANALOG_MIN);
      rated_speed = (nominal_value != ZERO_W) ? nominal_value : speed_rating;
      if (source_select == SRC_CURRENT) begin
         nom_eff = (nominal_value != ZERO_W) ? nominal_value : current_rating;
      end else if (speed_mode) begin
         nom_eff = rated_speed;
      end else begin
         nom_eff = nominal_value;
      end
      actual = (source_select == SRC_CURRENT) ? gen_current : analog_measure;
      if (analog_setpoint_assigned) begin
         desired = analog_setpoint;
      end else if ((source_select == SRC_CURRENT) && (setpoint_value == ZERO_W)) begin
         desired = current_rating;
      end else begin
         desired = setpoint_value;
      end
      if (source_select == SRC_BUMP) begin
         target = speed_setpoint;
      end else if (source_select == SRC_DIRECT) begin
         target = setpoint_value;
      end else begin
         target = desired;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Engine run sequence and activation delay.

   esr_state_t state;
   logic [W-1:0] sec_count;
   logic [7:0] sub_count;
   logic run_ok;
   logic loop_enable;
   logic cmd_accept;

   // Seconds are counted in ticks; the delay restarts on every engine start.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= ST_STOPPED;
         sec_count <= ZERO_W;
         sub_count <= 8'h00;
      end else if (!engine_running) begin
         state <= ST_STOPPED;
         sec_count <= ZERO_W;
         sub_count <= 8'h00;
      end else begin
         case (state)
            ST_STOPPED: begin
               state <= ST_DELAY;
            end
            ST_DELAY: begin
               if (sec_count >= activation_delay) begin
                  state <= ST_RUN;
               end else if (tick && (sub_count == 8'(TICK_HZ - 1))) begin
                  sub_count <= 8'h00;
                  sec_count <= sec_count + 16'h0001;
               end else if (tick) begin
                  sub_count <= sub_count + 8'h01;
               end
            end
            ST_RUN: begin
               state <= ST_RUN;
            end
            default: begin
               state <= ST_STOPPED;
            end
         endcase
      end
   end

   // Gating of the loop and of bump commands.
   always_comb begin
      run_ok = (state == ST_RUN);
      loop_enable = run_ok && (!loop_options[OPT_CLUTCH] || pin_level[IN_CLUTCH]);
      cmd_accept = run_ok && (!loop_options[OPT_BREAKER] || pin_level[IN_GCB])
                   && increase_assigned && decrease_assigned
                   && (source_select == SRC_BUMP);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bump speed setpoint.

   logic ev_inc;
   logic ev_dec;
   logic ev_rst;
   logic [W:0] sum_up;
   logic [W:0] floor_dn;

   always_comb begin
      ev_inc = cmd_accept && (pin_rise[IN_INC] || comm_increase);
      ev_dec = cmd_accept && (pin_rise[IN_DEC] || comm_decrease);
      ev_rst = cmd_accept && (pin_rise[IN_RST] || comm_reset);
      sum_up = {1'b0, speed_setpoint} + {1'b0, speed_step};
      floor_dn = {1'b0, min_speed} + {1'b0, speed_step};
   end

   // Outside bump mode the setpoint tracks the setting. Reset wins over steps.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         speed_setpoint <= ZERO_W;
      end else if (source_select != SRC_BUMP) begin
         speed_setpoint <= setpoint_value;
      end else if (ev_rst) begin
         speed_setpoint <= rated_speed;
      end else if (ev_inc) begin
         speed_setpoint <= (sum_up > {1'b0, max_speed}) ? max_speed : sum_up[W-1:0];
      end else if (ev_dec) begin
         speed_setpoint <= ({1'b0, speed_setpoint} < floor_dn) ? min_speed
                           : speed_setpoint - speed_step;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Ramp of the desired value or speed reference.

   logic [RW-1:0] ramp_q;
   logic [RW-1:0] target_q;
   logic [RW-1:0] step_q;
   logic [31:0] step_full;
   logic ramp_off;

   always_comb begin
      step_full = ({8'h00, nom_eff, 8'h00} * {24'h00_0000, ramp_rate}) / RAMP_DEN;
      step_q = (step_full[RW-1:0] == '0) ? RW'(1) : step_full[RW-1:0];
      target_q = {target, {FRAC{1'b0}}};
      ramp_off = (ramp_rate == RAMP_OFF_LO) || (ramp_rate == RAMP_OFF_HI);
   end

   // Fractional bits keep slow ramps from stalling at low nominal values.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ramp_q <= '0;
      end else if (!loop_enable) begin
         ramp_q <= speed_mode ? {idle_speed, {FRAC{1'b0}}} : {actual, {FRAC{1'b0}}};
      end else if (tick && ramp_off) begin
         ramp_q <= target_q;
      end else if (tick && (ramp_q < target_q)) begin
         ramp_q <= ((target_q - ramp_q) > step_q) ? ramp_q + step_q : target_q;
      end else if (tick && (ramp_q > target_q)) begin
         ramp_q <= ((ramp_q - target_q) > step_q) ? ramp_q - step_q : target_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Closed loop on the internal percentage command.

   logic signed [W:0] err;
   logic signed [31:0] err_pct;
   logic signed [31:0] err_abs;
   logic signed [47:0] corr;
   logic signed [47:0] cmd_next;
   logic in_band;

   always_comb begin
      if (loop_options[OPT_INVERT]) begin
         err = $signed({1'b0, actual}) - $signed({1'b0, ramp_q[RW-1:FRAC]});
      end else begin
         err = $signed({1'b0, ramp_q[RW-1:FRAC]}) - $signed({1'b0, actual});
      end
      if (nom_eff == ZERO_W) begin
         err_pct = 32'sd0;
      end else begin
         err_pct = (32'(err) * $signed({18'h0_0000, PCT_FULL}))
                   / $signed({16'h0000, nom_eff});
      end
      err_abs = (err_pct < 32'sd0) ? -err_pct : err_pct;
      in_band = err_abs <= $signed({18'h0_0000, dead_band});
      corr = (48'(err_pct) * $signed({32'h0000_0000, loop_gain})) >>> GAIN_SHIFT;
      cmd_next = $signed({34'h0, speed_command}) + corr;
   end

   // The next command is clamped to 0..100 %, so a large error cannot wrap the command.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         speed_command <= CMD_RESET;
      end else if (!loop_enable) begin
         speed_command <= (offset_command > PCT_FULL) ? PCT_FULL : offset_command;
      end else if (tick && loop_mode && !in_band) begin
         if (cmd_next < 48'sd0) begin
            speed_command <= CMD_RESET;
         end else if (cmd_next > $signed({34'h0, PCT_FULL})) begin
            speed_command <= PCT_FULL;
         end else begin
            speed_command <= cmd_next[13:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Speed request towards the governor.

   logic signed [W:0] span;
   logic signed [31:0] scaled;
   logic [W-1:0] map_rpm;
   logic [W-1:0] ramp_rpm;
   logic [W-1:0] next_request;

   always_comb begin
      span = $signed({1'b0, max_speed}) - $signed({1'b0, min_speed});
      scaled = (32'(span) * $signed({18'h0_0000, speed_command}))
               / $signed({18'h0_0000, PCT_FULL});
      map_rpm = W'($signed({16'h0000, min_speed}) + scaled);
      ramp_rpm = ramp_q[RW-1:FRAC];
      if (speed_mode && loop_enable) begin
         if (ramp_rpm > max_speed) begin
            next_request = max_speed;
         end else if (ramp_rpm < min_speed) begin
            next_request = min_speed;
         end else begin
            next_request = ramp_rpm;
         end
      end else begin
         next_request = map_rpm;
      end
   end

   // Outputs are registered once more so the governor sees clean values.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         speed_request <= ZERO_W;
         loop_active <= 1'b0;
      end else begin
         speed_request <= next_request;
         loop_active <= loop_enable;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   property p_offset;
      !loop_enable && (offset_command <= PCT_FULL) |=> speed_command == $past(offset_command);
   endproperty
   a_offset: assert property (p_offset) else $error("offset not applied");

   property p_cmd_range;
      speed_command <= PCT_FULL;
   endproperty
   a_cmd_range: assert property (p_cmd_range) else $error("command out of range");

   property p_bump_max;
      ev_inc && !ev_rst |=> speed_setpoint <= max_speed;
   endproperty
   a_bump_max: assert property (p_bump_max) else $error("increase above maximum");

   property p_bump_min;
      ev_dec && !ev_rst && !ev_inc && (speed_setpoint >= min_speed)
         |=> speed_setpoint >= min_speed;
   endproperty
   a_bump_min: assert property (p_bump_min) else $error("decrease below minimum");

   property p_reset_rated;
      ev_rst |=> speed_setpoint == $past(rated_speed);
   endproperty
   a_reset_rated: assert property (p_reset_rated) else $error("reset not rated");

   property p_ignore;
      (source_select == SRC_BUMP) && !cmd_accept |=> $stable(speed_setpoint);
   endproperty
   a_ignore: assert property (p_ignore) else $error("command taken while gated");

   property p_ramp_off;
      loop_enable && tick && ramp_off |=> ramp_q == $past(target_q);
   endproperty
   a_ramp_off: assert property (p_ramp_off) else $error("ramp not bypassed");

   property p_ramp_step;
      loop_enable && tick && !ramp_off && (ramp_q < target_q)
         |=> (ramp_q > $past(ramp_q)) && (ramp_q - $past(ramp_q) <= $past(step_q));
   endproperty
   a_ramp_step: assert property (p_ramp_step) else $error("ramp step wrong");

   property p_delay;
      $rose(run_ok) |-> sec_count >= activation_delay;
   endproperty
   a_delay: assert property (p_delay) else $error("loop started early");

   property p_band;
      loop_enable && tick && in_band |=> $stable(speed_command);
   endproperty
   a_band: assert property (p_band) else $error("command moved in dead band");
endmodule

// ===== tb/esr_plant_model.sv
// Purpose: Engine, governor and generator seen from the regulator.
// Assumes: Shaft speed follows the request one clock late.
// Notes:   Current rises with speed, so the current loop can close.
`timescale 1ns/1ps
module esr_plant_model (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Speed request from the regulator, rpm.
   input wire logic [15:0] speed_request,
   // Measured generator current.
   output logic [15:0] gen_current
);
   ////////////////////////////////////////////////////////////////
   // Current is speed over 64; crude, but its sign of slope is what matters.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gen_current <= 16'h0000;
      end else begin
         gen_current <= {6'h00, speed_request[15:6]};
      end
   end
endmodule

// ===== tb/tb_top.sv
// Purpose: Self-checking bench of the speed setpoint regulator.
// Assumes: TICK_DIV of 4, so one second is 400 clocks.
// Notes:   Inputs change on the falling edge only.
`timescale 1ns/1ps
module tb_top;
   import esr_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] src;
   logic [15:0] nom, setp, cur_rat, spd_rat, min_s, max_s, idle, step, gain, dly, ana;
   logic [15:0] gcur, req, spt;
   logic [7:0] ramp;
   logic [13:0] dband, offs, cmd;
   logic [2:0] opts, pins, cm;
   logic inc_as, dec_as, eng, brk, clu, act;
   logic ana_as;
   int error_cnt = 0;
   int comparisons = 0;
   int cyc = 0;
   ////////////////////////////////////////////////////////////////
   esr_regulator #(.TICK_DIV(4)) esr_regulator_i (.clk(clk), .rst(rst),
      .source_select(src), .nominal_value(nom), .setpoint_value(setp),
      .current_rating(cur_rat), .speed_rating(spd_rat), .min_speed(min_s),
      .max_speed(max_s), .idle_speed(idle), .speed_step(step), .ramp_rate(ramp),
      .dead_band(dband), .offset_command(offs), .loop_gain(gain),
      .activation_delay(dly), .loop_options(opts), .increase_assigned(inc_as),
      .decrease_assigned(dec_as), .gen_current(gcur), .analog_measure(ana),
      .analog_setpoint(ana), .analog_setpoint_assigned(ana_as),
      .engine_running(eng), .speed_increase_input(pins[0]),
      .speed_decrease_input(pins[1]), .speed_reset_input(pins[2]),
      .generator_breaker(brk), .clutch_engaged(clu), .comm_increase(cm[0]),
      .comm_decrease(cm[1]), .comm_reset(cm[2]), .speed_request(req),
      .speed_setpoint(spt), .speed_command(cmd), .loop_active(act));
   esr_plant_model esr_plant_model_i (.clk(clk), .rst(rst),
      .speed_request(req), .gen_current(gcur));
   ////////////////////////////////////////////////////////////////
   // Clock, and a ceiling on run length so a hang still ends the run.
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         complete_run();
      end
   end
   // Compares one value and counts the outcome.
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // Command k: 0..2 port inc/dec/reset, 3..5 the pins; n times, held h.
   task automatic bump(input int k, input int n, input int h);
      repeat (n) begin
         @(negedge clk);
         if (k < 3) cm[k] = 1'b1;
         else pins[k-3] = 1'b1;
         repeat (h) @(negedge clk);
         cm = 3'h0;
         pins = 3'h0;
         repeat (6) @(negedge clk);
      end
   endtask
   // Restarts the engine and waits, bounded, for the loop to come up.
   task automatic run(input int w);
      int n;
      n = 0;
      eng = 1'b0;
      repeat (3) @(negedge clk);
      eng = 1'b1;
      while (act !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      repeat (w) @(negedge clk);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // Main sequence; ramp is off until the ramp test so requests settle fast.
   initial begin
      src = 4'h3; nom = 16'h0708; setp = 16'h06a4; cur_rat = 16'h0028;
      spd_rat = 16'h0640; min_s = 16'h03e8; max_s = 16'h07d0; idle = 16'h04b0;
      step = 16'h0064; gain = 16'h0100; dly = 16'h0000; ana = 16'h0000;
      ramp = 8'h00; dband = 14'h0000; offs = 14'h1388; opts = 3'h0;
      pins = 3'h0; cm = 3'h0; inc_as = 1'b1; dec_as = 1'b1; eng = 1'b0;
      brk = 1'b1; clu = 1'b1;
      ana_as = 1'b0;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      chk("command", {2'h0, cmd}, 16'h1388);
      chk("request", req, 16'h05dc);
      run(20);
      chk("direct", req, 16'h06a4);
      setp = 16'h0640;
      repeat (20) @(negedge clk);
      chk("direct_new", req, 16'h0640);
      $display("test direct done");
      src = 4'h2;
      bump(0, 1, 1);
      chk("inc", spt, 16'h06a4);
      bump(0, 4, 1);
      chk("inc_max", spt, 16'h07d0);
      bump(4, 11, 6);
      chk("dec_min", spt, 16'h03e8);
      bump(5, 1, 6);
      chk("reset", spt, 16'h0708);
      nom = 16'h0000;
      bump(2, 1, 1);
      chk("reset_rating", spt, 16'h0640);
      bump(3, 1, 40);
      chk("held_pin", spt, 16'h06a4);
      inc_as = 1'b0;
      bump(0, 1, 1);
      chk("unassigned", spt, 16'h06a4);
      inc_as = 1'b1;
      opts = 3'h4;
      brk = 1'b0;
      // The breaker pin needs two synchroniser edges before it gates commands.
      repeat (3) @(negedge clk);
      bump(0, 1, 1);
      chk("breaker_open", spt, 16'h06a4);
      brk = 1'b1;
      repeat (3) @(negedge clk);
      bump(0, 1, 1);
      chk("breaker_shut", spt, 16'h0708);
      repeat (20) @(negedge clk);
      chk("bump_req", req, 16'h0708);
      opts = 3'h0;
      dly = 16'h0001;
      eng = 1'b0;
      repeat (3) @(negedge clk);
      eng = 1'b1;
      bump(0, 8, 1);
      chk("early", spt, 16'h0708);
      chk("early_act", {15'h0, act}, 16'h0000);
      $display("test bump done");
      dly = 16'h0000;
      ramp = 8'h0a;
      nom = 16'h03e8;
      idle = 16'h06a4;
      run(100);
      chk("ramping", {15'h0, req > 16'h06a4 && req < 16'h0708}, 16'h0001);
      repeat (500) @(negedge clk);
      chk("ramp_end", req, 16'h0708);
      opts = 3'h2;
      clu = 1'b0;
      repeat (5) @(negedge clk);
      chk("clutch", {15'h0, act}, 16'h0000);
      chk("clutch_req", req, 16'h05dc);
      clu = 1'b1;
      $display("test ramp done");
      src = 4'h1;
      ramp = 8'h00;
      nom = 16'h0000;
      setp = 16'h0000;
      for (int i = 0; i < 3; i++) begin
         opts = (i == 1) ? 3'h1 : 3'h0;
         dband = (i == 2) ? 14'h2710 : 14'h0000;
         run(200);
         chk("loop", {15'h0, i == 0 ? cmd > offs : i == 1 ? cmd < offs : cmd == offs},
            16'h0001);
      end
      $display("test current done");
      // Analogue source: measure below setting drives the command up.
      src = 4'h4;
      nom = 16'h03e8;
      setp = 16'h0064;
      ana = 16'h0032;
      opts = 3'h0;
      dband = 14'h0000;
      run(200);
      chk("analog", {15'h0, cmd > offs}, 16'h0001);
      // With the analogue setpoint in use, desired equals measure, so no error.
      ana_as = 1'b1;
      run(200);
      chk("analog_setp", {2'h0, cmd}, {2'h0, offs});
      $display("test analog done");
      complete_run();
   end
endmodule
